// ### rtl/fmpc_pkg.sv
// package: register map, field layout, reset values and codes of the float-mode config bank
package fmpc_pkg;

  // register indices as printed (not all multiples of four): byte address = 4 * index
  localparam logic [7:0]  FMPC_IDX_MATH     = 8'h58;
  localparam logic [7:0]  FMPC_IDX_EN_PRE_B = 8'h59;
  localparam logic [7:0]  FMPC_IDX_FIRE     = 8'h5a;
  localparam logic [7:0]  FMPC_IDX_EN_PRE_A = 8'h5e;
  localparam logic [7:0]  FMPC_IDX_STATUS   = 8'h70;
  localparam logic [7:0]  FMPC_IDX_SEQ      = 8'h71;

  // field positions
  localparam int FMPC_EN_LSB       = 13;
  localparam int FMPC_PRE_LSB      = 8;
  localparam int FMPC_FIRE_B_LSB   = 12;
  localparam int FMPC_FIRE_A_LSB   = 8;
  localparam int FMPC_M12A_LSB     = 1;
  localparam int FMPC_M34A_LSB     = 8;
  localparam int FMPC_PAIR_W       = 2;
  localparam int FMPC_EN_W         = 2;
  localparam int FMPC_PRE_W        = 5;
  localparam int FMPC_FIRE_W       = 4;

  // reset values
  localparam logic [1:0]  FMPC_EN_RST    = 2'h0;
  localparam logic [4:0]  FMPC_PRE_RST   = 5'h08;
  localparam logic [3:0]  FMPC_FIRE_RST  = 4'h0;
  localparam logic [1:0]  FMPC_PAIR_RST  = 2'h0;
  localparam logic [7:0]  FMPC_LOW_EN_PRE = 8'h08;
  localparam logic [7:0]  FMPC_LOW_FIRE  = 8'h10;

  // enable codes
  localparam logic [1:0]  FMPC_EN_OFF    = 2'h0;
  localparam logic [1:0]  FMPC_EN_ON     = 2'h3;

  // precondition step: one code unit = 2 us (reset code 8 gives 16 us)
  localparam int FMPC_PRE_STEP_NS = 2000;
  localparam int FMPC_CLK_NS      = 100;
  localparam int FMPC_PRE_STEP_CYC = FMPC_PRE_STEP_NS / FMPC_CLK_NS;

  // axi responses
  localparam logic [1:0]  FMPC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  FMPC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FMPC_SEQ_IDLE = 2'b00,
    FMPC_SEQ_PRE  = 2'b01,
    FMPC_SEQ_RUN  = 2'b10
  } fmpc_seq_e;

endpackage : fmpc_pkg

// ### rtl/fmpc_pair_sign.sv
// module: turns a pair-sign code and group position into add/subtract for one sample
`timescale 1ns/1ps
module fmpc_pair_sign
  import fmpc_pkg::*;
(
  input  wire logic [1:0] pair12_code,
  input  wire logic [1:0] pair34_code,
  input  wire logic [1:0] group_pos,
  output logic            subtract
);
  // within a pair: high code bit governs the first sample, low bit the second
  always_comb begin
    case (group_pos)
      2'h0: subtract = pair12_code[1];
      2'h1: subtract = pair12_code[0];
      2'h2: subtract = pair34_code[1];
      2'h3: subtract = pair34_code[0];
      default: subtract = 1'b0;
    endcase
  end
endmodule : fmpc_pair_sign

// ### rtl/fmpc_slot_seq.sv
// module: float sequence for one time slot: precondition wait, then pulse walk with fire mask
`timescale 1ns/1ps
module fmpc_slot_seq
  import fmpc_pkg::*;
#(
  parameter int PRE_STEP_CYC = FMPC_PRE_STEP_CYC
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       slot_start,
  input  wire logic       pulse_tick,
  input  wire logic [1:0] float_enable,
  input  wire logic [4:0] precondition_time,
  input  wire logic [3:0] fire_pattern,
  output logic            busy,
  output logic            pulse_strobe,
  output logic            led_fire,
  output logic [1:0]      group_pos
);
  typedef struct packed {
    fmpc_seq_e  st;
    logic [4:0] pre_cnt;
    logic [15:0] step_cnt;
    logic [1:0] pos;
    logic       strobe;
    logic       fire;
  } fmpc_seq_s;

  fmpc_seq_s s_r;
  fmpc_seq_s s_nxt;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.strobe = 1'b0;
    s_nxt.fire   = 1'b0;
    case (s_r.st)
      FMPC_SEQ_IDLE: begin
        // reserved enable codes leave float off
        if (slot_start && float_enable == FMPC_EN_ON) begin
          s_nxt.st       = FMPC_SEQ_PRE;
          s_nxt.pre_cnt  = precondition_time;
          s_nxt.step_cnt = 16'h0000;
          s_nxt.pos      = 2'h0;
        end
      end
      FMPC_SEQ_PRE: begin
        if (s_r.pre_cnt == 5'h00) begin
          s_nxt.st = FMPC_SEQ_RUN;
        end else if (s_r.step_cnt == 16'(PRE_STEP_CYC - 1)) begin
          s_nxt.step_cnt = 16'h0000;
          s_nxt.pre_cnt  = s_r.pre_cnt - 5'h01;
        end else begin
          s_nxt.step_cnt = s_r.step_cnt + 16'h0001;
        end
      end
      FMPC_SEQ_RUN: begin
        if (float_enable != FMPC_EN_ON) begin
          s_nxt.st = FMPC_SEQ_IDLE;
        end else if (pulse_tick) begin
          // timing runs for every position; a set bit only masks the led
          s_nxt.strobe = 1'b1;
          s_nxt.fire   = ~fire_pattern[s_r.pos];
          s_nxt.pos    = s_r.pos + 2'h1;
        end
      end
      default: s_nxt.st = FMPC_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r.st       <= FMPC_SEQ_IDLE;
      s_r.pre_cnt  <= 5'h00;
      s_r.step_cnt <= 16'h0000;
      s_r.pos      <= 2'h0;
      s_r.strobe   <= 1'b0;
      s_r.fire     <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy         = (s_r.st != FMPC_SEQ_IDLE);
  assign pulse_strobe = s_r.strobe;
  assign led_fire     = s_r.fire;
  // position of the pulse just strobed
  assign group_pos    = s_r.pos - 2'h1;
endmodule : fmpc_slot_seq

// ### rtl/fmpc_top.sv
// module: float-mode pulse configuration bank with AXI4-Lite slave and two slot sequencers
// What this block does
// - slot A pair12 code: 00 add,add; 01 add,sub; 10 sub,add; 11 sub,sub.
// - the pair12 setting repeats for every four-pulse group of a burst.
// - slot B float enable: 0 off, 3 on; 1 and 2 reserved.
// - slot A float enable: 0 off by default, 3 on; 1 and 2 reserved.
// - slot B five-bit precondition time, reset 0x08, about 16 us.
// - slot A five-bit precondition time, reset 0x08.
// - pattern bit 0 fires the led, 1 masks it; timing still runs.
// - slot B fire pattern bits 15:12, bit 12 first pulse, reset all fire.
// - slot A fire pattern bits 11:8, bit 8 first pulse, reset all fire.
// - slot A pair34 code combines samples three and four, same codes.
`timescale 1ns/1ps
module fmpc_top
  import fmpc_pkg::*;
#(
  parameter int PRE_STEP_CYC = FMPC_PRE_STEP_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        slot_a_start,
  input  wire logic        slot_b_start,
  input  wire logic        pulse_tick,
  output logic             slot_a_led_fire,
  output logic             slot_a_pulse_strobe,
  output logic             slot_a_sample_subtract,
  output logic             slot_b_led_fire,
  output logic             slot_b_pulse_strobe
);
  typedef struct packed {
    logic [15:0] math_reg;
    logic [15:0] en_pre_b;
    logic [15:0] fire_reg;
    logic [15:0] en_pre_a;
    logic        aw_held;
    logic [9:0]  awaddr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        a_fire;
    logic        a_strobe;
    logic        a_sub;
    logic        b_fire;
    logic        b_strobe;
  } fmpc_top_s;

  fmpc_top_s s_r;
  fmpc_top_s s_nxt;

  logic       a_busy;
  logic       b_busy;
  logic       a_strobe;
  logic       b_strobe;
  logic       a_fire;
  logic       b_fire;
  logic [1:0] a_pos;
  logic       a_sub;

  // slots run from separate fields and separate sequencers
  fmpc_slot_seq #(
    .PRE_STEP_CYC (PRE_STEP_CYC)
  ) u_seq_a (
    .clk               (clk),
    .srst              (srst),
    .slot_start        (slot_a_start),
    .pulse_tick        (pulse_tick),
    .float_enable      (s_r.en_pre_a[FMPC_EN_LSB +: FMPC_EN_W]),
    .precondition_time (s_r.en_pre_a[FMPC_PRE_LSB +: FMPC_PRE_W]),
    .fire_pattern      (s_r.fire_reg[FMPC_FIRE_A_LSB +: FMPC_FIRE_W]),
    .busy              (a_busy),
    .pulse_strobe      (a_strobe),
    .led_fire          (a_fire),
    .group_pos         (a_pos)
  );

  fmpc_slot_seq #(
    .PRE_STEP_CYC (PRE_STEP_CYC)
  ) u_seq_b (
    .clk               (clk),
    .srst              (srst),
    .slot_start        (slot_b_start),
    .pulse_tick        (pulse_tick),
    .float_enable      (s_r.en_pre_b[FMPC_EN_LSB +: FMPC_EN_W]),
    .precondition_time (s_r.en_pre_b[FMPC_PRE_LSB +: FMPC_PRE_W]),
    .fire_pattern      (s_r.fire_reg[FMPC_FIRE_B_LSB +: FMPC_FIRE_W]),
    .busy              (b_busy),
    .pulse_strobe      (b_strobe),
    .led_fire          (b_fire),
    .group_pos         ()
  );

  fmpc_pair_sign u_sign_a (
    .pair12_code (s_r.math_reg[FMPC_M12A_LSB +: FMPC_PAIR_W]),
    .pair34_code (s_r.math_reg[FMPC_M34A_LSB +: FMPC_PAIR_W]),
    .group_pos   (a_pos),
    .subtract    (a_sub)
  );

  function automatic logic [15:0] fmpc_merge(input logic [15:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [15:0] v;
    v = old_v;
    if (st[0]) begin
      v[7:0] = wd[7:0];
    end
    if (st[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction : fmpc_merge

  logic       do_write;
  logic [7:0] w_idx;
  logic [7:0] r_idx;
  logic       w_aligned;
  logic       r_aligned;

  always_comb begin
    do_write  = s_r.aw_held && s_r.w_held && !s_r.bvalid;
    w_idx     = s_r.awaddr[9:2];
    r_idx     = s_axi_araddr[9:2];
    w_aligned = (s_r.awaddr[1:0] == 2'h0);
    r_aligned = (s_axi_araddr[1:0] == 2'h0);
  end

  always_comb begin
    s_nxt = s_r;
    // write address and data accepted in either order, held until answered
    if (s_axi_awvalid && !s_r.aw_held) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_held) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata  = s_axi_wdata;
      s_nxt.wstrb  = s_axi_wstrb;
    end
    if (do_write) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = FMPC_RESP_OKAY;
      // each field keeps its value until written again
      if (!w_aligned) begin
        s_nxt.bresp = FMPC_RESP_SLVERR;
      end else begin
        case (w_idx)
          FMPC_IDX_MATH:     s_nxt.math_reg = fmpc_merge(s_r.math_reg, s_r.wdata, s_r.wstrb);
          FMPC_IDX_EN_PRE_B: s_nxt.en_pre_b = fmpc_merge(s_r.en_pre_b, s_r.wdata, s_r.wstrb);
          FMPC_IDX_FIRE:     s_nxt.fire_reg = fmpc_merge(s_r.fire_reg, s_r.wdata, s_r.wstrb);
          FMPC_IDX_EN_PRE_A: s_nxt.en_pre_a = fmpc_merge(s_r.en_pre_a, s_r.wdata, s_r.wstrb);
          FMPC_IDX_STATUS:   s_nxt.bresp    = FMPC_RESP_OKAY;
          FMPC_IDX_SEQ:      s_nxt.bresp    = FMPC_RESP_OKAY;
          default:           s_nxt.bresp    = FMPC_RESP_SLVERR;
        endcase
      end
    end else if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    if (s_axi_arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = FMPC_RESP_OKAY;
      s_nxt.rdata  = 32'h0000_0000;
      if (!r_aligned) begin
        s_nxt.rresp = FMPC_RESP_SLVERR;
      end else begin
        case (r_idx)
          FMPC_IDX_MATH:     s_nxt.rdata = {16'h0000, s_r.math_reg};
          FMPC_IDX_EN_PRE_B: s_nxt.rdata = {16'h0000, s_r.en_pre_b};
          FMPC_IDX_FIRE:     s_nxt.rdata = {16'h0000, s_r.fire_reg};
          FMPC_IDX_EN_PRE_A: s_nxt.rdata = {16'h0000, s_r.en_pre_a};
          FMPC_IDX_STATUS:   s_nxt.rdata = {30'h0000_0000, b_busy, a_busy};
          FMPC_IDX_SEQ:      s_nxt.rdata = {28'h000_0000, a_pos, b_fire, a_fire};
          default:           s_nxt.rresp = FMPC_RESP_SLVERR;
        endcase
      end
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    s_nxt.a_fire   = a_fire;
    s_nxt.a_strobe = a_strobe;
    s_nxt.a_sub    = a_sub;
    s_nxt.b_fire   = b_fire;
    s_nxt.b_strobe = b_strobe;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.math_reg <= 16'h0000;
      s_r.en_pre_b <= {1'b0, FMPC_EN_RST, FMPC_PRE_RST, FMPC_LOW_EN_PRE};
      s_r.fire_reg <= {FMPC_FIRE_RST, FMPC_FIRE_RST, FMPC_LOW_FIRE};
      s_r.en_pre_a <= {1'b0, FMPC_EN_RST, FMPC_PRE_RST, FMPC_LOW_EN_PRE};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ready flags are registered state: no combinational path from valid
  always_comb begin
    s_axi_awready          = !s_r.aw_held;
    s_axi_wready           = !s_r.w_held;
    s_axi_arready          = !s_r.rvalid;
    s_axi_bvalid           = s_r.bvalid;
    s_axi_bresp            = s_r.bresp;
    s_axi_rvalid           = s_r.rvalid;
    s_axi_rdata            = s_r.rdata;
    s_axi_rresp            = s_r.rresp;
    slot_a_led_fire        = s_r.a_fire;
    slot_a_pulse_strobe    = s_r.a_strobe;
    slot_a_sample_subtract = s_r.a_sub;
    slot_b_led_fire        = s_r.b_fire;
    slot_b_pulse_strobe    = s_r.b_strobe;
  end
endmodule : fmpc_top

// ### verification/fmpc_chk.sv
// checker: port-level properties of the float-mode config bank
`timescale 1ns/1ps
module fmpc_chk
  import fmpc_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        pulse_tick,
  input wire logic        slot_a_led_fire,
  input wire logic        slot_a_pulse_strobe,
  input wire logic        slot_b_led_fire,
  input wire logic        slot_b_pulse_strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_rd_ans; s_axi_rvalid; endsequence
  property p_rd_answer; s_rd_take |=> s_rd_ans; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  // a write may only be answered after its address was held off
  property p_b_after; $rose(s_axi_bvalid) |-> $past(!s_axi_awready) && $past(!s_axi_wready); endproperty
  a_b_after: assert property (p_b_after) else $error("write answered without take");
  property p_err_zero; s_axi_rvalid && s_axi_rresp == FMPC_RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read with data");
  property p_a_fire; slot_a_led_fire |-> slot_a_pulse_strobe; endproperty
  a_a_fire: assert property (p_a_fire) else $error("slot a fire outside a pulse");
  property p_b_fire; slot_b_led_fire |-> slot_b_pulse_strobe; endproperty
  a_b_fire: assert property (p_b_fire) else $error("slot b fire outside a pulse");
  property p_a_tick; slot_a_pulse_strobe |-> $past(pulse_tick, 2); endproperty
  a_a_tick: assert property (p_a_tick) else $error("slot a pulse without tick");
  property p_b_tick; slot_b_pulse_strobe |-> $past(pulse_tick, 2); endproperty
  a_b_tick: assert property (p_b_tick) else $error("slot b pulse without tick");
endmodule : fmpc_chk

// ### verification/fmpc_top_test.sv
// testbench: register and float-sequence scenarios for the config bank
`timescale 1ns/1ps
module fmpc_top_test;
  import fmpc_pkg::*;
  logic        clk = 0, srst = 1;
  logic [9:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        slot_a_start = 0, slot_b_start = 0, pulse_tick = 0;
  logic        slot_a_led_fire, slot_a_pulse_strobe, slot_a_sample_subtract;
  logic        slot_b_led_fire, slot_b_pulse_strobe;
  int          n_fail = 0, n_tests = 0, cyc = 0;
  // expected fire and subtract per group position, bit index = position
  localparam logic [3:0] FA = 4'b1010, UA = 4'b1001, FB = 4'b0111;
  // short precondition step keeps the run brief
  fmpc_top #(.PRE_STEP_CYC(2)) u_dut (
    .clk                    (clk),
    .srst                   (srst),
    .s_axi_awaddr           (s_axi_awaddr),
    .s_axi_awvalid          (s_axi_awvalid),
    .s_axi_awready          (s_axi_awready),
    .s_axi_wdata            (s_axi_wdata),
    .s_axi_wstrb            (s_axi_wstrb),
    .s_axi_wvalid           (s_axi_wvalid),
    .s_axi_wready           (s_axi_wready),
    .s_axi_bresp            (s_axi_bresp),
    .s_axi_bvalid           (s_axi_bvalid),
    .s_axi_bready           (s_axi_bready),
    .s_axi_araddr           (s_axi_araddr),
    .s_axi_arvalid          (s_axi_arvalid),
    .s_axi_arready          (s_axi_arready),
    .s_axi_rdata            (s_axi_rdata),
    .s_axi_rresp            (s_axi_rresp),
    .s_axi_rvalid           (s_axi_rvalid),
    .s_axi_rready           (s_axi_rready),
    .slot_a_start           (slot_a_start),
    .slot_b_start           (slot_b_start),
    .pulse_tick             (pulse_tick),
    .slot_a_led_fire        (slot_a_led_fire),
    .slot_a_pulse_strobe    (slot_a_pulse_strobe),
    .slot_a_sample_subtract (slot_a_sample_subtract),
    .slot_b_led_fire        (slot_b_led_fire),
    .slot_b_pulse_strobe    (slot_b_pulse_strobe)
  );
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    chk("bresp", e, s_axi_bresp);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 0;
    chk("rdata", ed, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask : rd
  // one pulse position; strobes are gathered over a window since they stand one cycle
  task automatic tick(input logic ea, input int p, input logic eb);
    logic sa, fa, ua, sb, fb;
    {sa, fa, ua, sb, fb} = '0;
    @(posedge clk) pulse_tick <= 1;
    @(posedge clk) pulse_tick <= 0;
    repeat (4) begin
      @(posedge clk);
      sa |= slot_a_pulse_strobe;
      fa |= slot_a_led_fire;
      ua |= slot_a_pulse_strobe & slot_a_sample_subtract;
      sb |= slot_b_pulse_strobe;
      fb |= slot_b_led_fire;
    end
    chk("a_strobe", ea, sa);
    chk("a_fire", ea & FA[p], fa);
    chk("a_subtract", ea & UA[p], ua);
    chk("b_strobe", eb, sb);
    chk("b_fire", eb & FB[p], fb);
  endtask : tick
  task automatic start(input logic a, input logic b);
    @(posedge clk);
    slot_a_start <= a;
    slot_b_start <= b;
    @(posedge clk);
    slot_a_start <= 0;
    slot_b_start <= 0;
  endtask : start
  task automatic t_reset;
    logic [9:0] ad[6] = '{10'h160, 10'h164, 10'h168, 10'h178, 10'h100, 10'h161};
    logic [31:0] ev[6] = '{32'h0, 32'h0808, 32'h0010, 32'h0808, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) rd(ad[i], ev[i], i < 4 ? FMPC_RESP_OKAY : FMPC_RESP_SLVERR);
    $display("done t_reset");
  endtask : t_reset
  task automatic t_rw;
    logic [9:0] ad[4] = '{10'h160, 10'h168, 10'h178, 10'h164};
    logic [31:0] dv[4] = '{32'hff000104, 32'h00ff8510, 32'hf0006108, 32'h0f000108};
    for (int i = 0; i < 4; i++) wr(ad[i], dv[i], FMPC_RESP_OKAY);
    wr(10'h100, 32'hffff, FMPC_RESP_SLVERR);
    for (int i = 0; i < 4; i++) rd(ad[i], dv[i] & 32'hffff, FMPC_RESP_OKAY);
    $display("done t_rw");
  endtask : t_rw
  task automatic t_seq_a;
    start(1, 1);
    repeat (10) @(posedge clk);
    // eight ticks cover two groups; slot b stays off while its enable is 0
    for (int i = 0; i < 8; i++) tick(1, i % 4, 0);
    $display("done t_seq_a");
  endtask : t_seq_a
  task automatic t_off;
    wr(10'h178, 32'h0108, FMPC_RESP_OKAY);
    tick(0, 0, 0);
    $display("done t_off");
  endtask : t_off
  task automatic t_seq_b;
    wr(10'h164, 32'h7008, FMPC_RESP_OKAY);
    start(0, 1);
    tick(0, 0, 0);
    // code 16 at step 2 spans 32 cycles: a tick 32 cycles after start is still refused
    repeat (24) @(posedge clk);
    tick(0, 0, 0);
    for (int i = 0; i < 4; i++) tick(0, i, 1);
    $display("done t_seq_b");
  endtask : t_seq_b
  initial begin
    repeat (2) @(posedge clk);
    srst <= 0;
    t_reset();
    t_rw();
    t_seq_a();
    t_off();
    t_seq_b();
    summarize();
  end
endmodule : fmpc_top_test
bind fmpc_top fmpc_chk u_chk (
  .clk                 (clk),
  .srst                (srst),
  .s_axi_awready       (s_axi_awready),
  .s_axi_wready        (s_axi_wready),
  .s_axi_bvalid        (s_axi_bvalid),
  .s_axi_bready        (s_axi_bready),
  .s_axi_bresp         (s_axi_bresp),
  .s_axi_arvalid       (s_axi_arvalid),
  .s_axi_arready       (s_axi_arready),
  .s_axi_rvalid        (s_axi_rvalid),
  .s_axi_rready        (s_axi_rready),
  .s_axi_rdata         (s_axi_rdata),
  .s_axi_rresp         (s_axi_rresp),
  .pulse_tick          (pulse_tick),
  .slot_a_led_fire     (slot_a_led_fire),
  .slot_a_pulse_strobe (slot_a_pulse_strobe),
  .slot_b_led_fire     (slot_b_led_fire),
  .slot_b_pulse_strobe (slot_b_pulse_strobe)
);
